// file: core/mcao_pkg.sv
/*
  Package for the monitor configuration and remote-2 offset register block.
  Assumes an APB master with 32-bit data; registers sit one per aligned word.
*/
package mcao_pkg;
  // ==========================================================
  // Register map (byte addresses = printed index times four)
  localparam logic [7:0]  IDX_R2_OFFSET    = 8'h72;
  localparam logic [7:0]  IDX_CONFIG_TWO   = 8'h73;
  localparam logic [7:0]  IDX_CTRL_OWN     = 8'h80;
  localparam logic [7:0]  IDX_STATUS_OWN   = 8'h81;
  localparam logic [11:0] ADDR_R2_OFFSET   = 12'h1c8;
  localparam logic [11:0] ADDR_CONFIG_TWO  = 12'h1cc;
  localparam logic [11:0] ADDR_CTRL_OWN    = 12'h200;
  localparam logic [11:0] ADDR_STATUS_OWN  = 12'h204;
  // ==========================================================
  // Reset values
  localparam logic [7:0]  RST_R2_OFFSET    = 8'h00;
  localparam logic [7:0]  RST_CONFIG_TWO   = 8'h00;
  localparam logic [7:0]  RST_CTRL_OWN     = 8'h00;
  // ==========================================================
  // Field positions of the configuration register
  localparam int          POS_FAN_SENSE_LO = 0;
  localparam int          NUM_FANS         = 4;
  localparam int          POS_AVG_DIS      = 4;
  localparam int          POS_ATTENUATOR_BYPASS_BYP     = 5;
  localparam int          POS_SINGLE       = 6;
  localparam int          POS_SHUTDOWN     = 7;
  // Own control register: lock, invert, external start, channel select
  localparam int          POS_LOCK         = 0;
  localparam int          POS_INVERT       = 1;
  localparam int          POS_EXT_START    = 2;
  localparam int          POS_CHAN_LO      = 5;
  localparam int          NUM_PWM          = 3;
  localparam logic [2:0]  CHAN_REMOTE2     = 3'h7;
  // ==========================================================
  // Conversion timing in cycles of clk_sys
  localparam logic [7:0]  SINGLE_CHANNEL_MODE_CYC_AVG     = 8'h40;
  localparam logic [7:0]  SINGLE_CHANNEL_MODE_CYC_FAST    = 8'h04;
  localparam logic [31:0] PSLVERR_OFF      = 32'h0000_0000;
  typedef enum logic [1:0] {MCAO_IDLE, MCAO_SCAN, MCAO_SINGLE, MCAO_OFF} mcao_mode_e;
endpackage

// file: core/mcao_offset_add.sv
/*
  Adds the signed quarter-degree offset to a 10-bit remote-2 reading.
  Assumes reading and offset are both in quarter-degree units.
*/
`timescale 1ns/10ps
module mcao_offset_add (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              raw_valid,
  input  wire logic [9:0]        raw_temp,
  input  wire logic [7:0]        offset,
  output logic                   cor_valid_ff,
  output logic [9:0]             cor_temp_ff
);
  logic [10:0] nxt_sum;
  // ==========================================================
  // Sign-extend the offset; result wraps like the raw register
  always_comb begin
    nxt_sum = {1'b0, raw_temp} + {{3{offset[7]}}, offset};
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cor_valid_ff <= 1'b0;
      cor_temp_ff  <= 10'h000;
    end else begin
      cor_valid_ff <= raw_valid;
      if (raw_valid) begin
        cor_temp_ff <= nxt_sum[9:0];
      end
    end
  end
endmodule

// file: core/mcao_single_channel_mode_seq.sv
/*
  Conversion sequencer: round robin over eight channels or one chosen channel.
  Assumes the measurement engine accepts one start pulse per conversion.
*/
`timescale 1ns/10ps
module mcao_single_channel_mode_seq (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              single_mode,
  input  wire logic              averaging_off,
  input  wire logic              halt,
  input  wire logic              ext_start_en,
  input  wire logic              ext_start,
  input  wire logic [2:0]        chan_sel,
  output logic                   single_channel_mode_start_ff,
  output logic [2:0]             single_channel_mode_chan_ff
);
  logic [7:0] wait_ff;
  logic [7:0] nxt_period;
  logic       ext_prev_ff;
  logic       ext_rise;
  logic       tick;
  always_comb begin
    nxt_period = averaging_off ? mcao_pkg::SINGLE_CHANNEL_MODE_CYC_FAST : mcao_pkg::SINGLE_CHANNEL_MODE_CYC_AVG;
    ext_rise   = ext_start & ~ext_prev_ff;
    tick       = (single_mode && ext_start_en) ? ext_rise : (wait_ff == 8'h00);
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ext_prev_ff <= 1'b0;
    end else begin
      ext_prev_ff <= ext_start;
    end
  end
  // ==========================================================
  // Start pacing and channel stepping
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wait_ff       <= mcao_pkg::SINGLE_CHANNEL_MODE_CYC_AVG;
      single_channel_mode_start_ff <= 1'b0;
      single_channel_mode_chan_ff  <= 3'h0;
    end else if (halt) begin
      wait_ff       <= nxt_period;
      single_channel_mode_start_ff <= 1'b0;
    end else begin
      single_channel_mode_start_ff <= tick;
      wait_ff       <= tick ? nxt_period - 8'h01 : (wait_ff - 8'h01);
      if (tick) begin
        if (single_mode) begin
          single_channel_mode_chan_ff <= chan_sel;
        end else begin
          single_channel_mode_chan_ff <= single_channel_mode_chan_ff + 3'h1;
        end
      end
    end
  end
endmodule

// file: core/mcao_top.sv
/*
  Configuration register two and remote-2 temperature offset, on APB.
  Assumes a single synchronous APB master on clk_sys at 20 MHz.
*/
// Function
// - The remote-2 reading has the signed quarter-degree offset added to it.
// - While the lock bit is one, writes to both registers are ignored.
// - Both registers reset to zero.
// - Each of bits 0 to 3 selects two-wire sensing on its fan input when one.
// - Bit 4 turns averaging off so conversions run faster.
// - Bit 5 bypasses the attenuators on four voltage inputs.
// - Bit 6 selects single-channel repeated conversion.
// - In single-channel mode a 3-bit code chooses the input, 7 meaning remote 2.
// - With external start enabled, single-channel conversions start on an external edge.
// - Bit 7 shuts down and drives every PWM output to its fan-off level.
// - In shutdown the current duty readback is zero.
`timescale 1ns/10ps
module mcao_top (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic              raw_valid,
  input  wire logic [9:0]        raw_remote2,
  input  wire logic [7:0]        duty_now,
  input  wire logic [2:0]        pwm_in,
  input  wire logic              ext_start,
  output logic                   cor_valid_ff,
  output logic [9:0]             cor_remote2_ff,
  output logic [3:0]             fan_two_wire_sense_ff,
  output logic                   averaging_disable_ff,
  output logic                   attenuator_bypass_ff,
  output logic                   single_channel_mode_ff,
  output logic                   shutdown_request_ff,
  output logic [2:0]             pwm_out_ff,
  output logic                   single_channel_mode_start_ff,
  output logic [2:0]             single_channel_mode_chan_ff
);
  logic [7:0]  offset_ff;
  logic [7:0]  config_ff;
  logic [7:0]  ctrl_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic [31:0] nxt_prdata;
  logic        acc;
  logic        wr;
  logic        locked;
  logic        pwm_output_invert;
  logic [2:0]  pwm_fan_off;
  mcao_pkg::mcao_mode_e mode_ff;

  assign pready  = pready_ff;
  assign prdata  = prdata_ff;
  assign pslverr = mcao_pkg::PSLVERR_OFF[0];

  // ==========================================================
  // APB access: one wait state, answer on second access edge
  // Writes land only on the edge where the master sees pready high
  always_comb begin
    acc               = psel & penable & ~pready_ff;
    wr                = psel & penable & pready_ff & pwrite;
    locked            = ctrl_ff[mcao_pkg::POS_LOCK];
    pwm_output_invert = ctrl_ff[mcao_pkg::POS_INVERT];
    pwm_fan_off       = {mcao_pkg::NUM_PWM{pwm_output_invert}};
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= acc;
    end
  end

  // ==========================================================
  // Locked registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      offset_ff <= mcao_pkg::RST_R2_OFFSET;
      config_ff <= mcao_pkg::RST_CONFIG_TWO;
    end else if (wr && !locked) begin
      if (paddr == mcao_pkg::ADDR_R2_OFFSET) begin
        offset_ff <= pwdata[7:0];
      end
      if (paddr == mcao_pkg::ADDR_CONFIG_TWO) begin
        config_ff <= pwdata[7:0];
      end
    end
  end

  // Own control register; lock is sticky until reset so software cannot undo it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_ff <= mcao_pkg::RST_CTRL_OWN;
    end else if (wr && paddr == mcao_pkg::ADDR_CTRL_OWN) begin
      ctrl_ff <= pwdata[7:0] | {7'h00, locked};
    end
  end

  // ==========================================================
  // Read mux
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    unique case (paddr)
      mcao_pkg::ADDR_R2_OFFSET:  nxt_prdata = {24'h000000, offset_ff};
      mcao_pkg::ADDR_CONFIG_TWO: nxt_prdata = {24'h000000, config_ff};
      mcao_pkg::ADDR_CTRL_OWN:   nxt_prdata = {24'h000000, ctrl_ff};
      mcao_pkg::ADDR_STATUS_OWN: begin
        nxt_prdata = {24'h000000, shutdown_request_ff ? 8'h00 : duty_now};
      end
      default:                   nxt_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prdata_ff <= 32'h0000_0000;
    end else if (acc && !pwrite) begin
      prdata_ff <= nxt_prdata;
    end
  end

  // ==========================================================
  // Configuration fan-out
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fan_two_wire_sense_ff  <= 4'h0;
      averaging_disable_ff   <= 1'b0;
      attenuator_bypass_ff   <= 1'b0;
      single_channel_mode_ff <= 1'b0;
      shutdown_request_ff    <= 1'b0;
    end else begin
      fan_two_wire_sense_ff  <= config_ff[mcao_pkg::NUM_FANS-1:0];
      averaging_disable_ff   <= config_ff[mcao_pkg::POS_AVG_DIS];
      attenuator_bypass_ff   <= config_ff[mcao_pkg::POS_ATTENUATOR_BYPASS_BYP];
      single_channel_mode_ff <= config_ff[mcao_pkg::POS_SINGLE];
      shutdown_request_ff    <= config_ff[mcao_pkg::POS_SHUTDOWN];
    end
  end

  // PWM outputs forced to fan-off level in shutdown
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pwm_out_ff <= 3'h0;
    end else if (config_ff[mcao_pkg::POS_SHUTDOWN]) begin
      pwm_out_ff <= pwm_fan_off;
    end else begin
      pwm_out_ff <= pwm_in ^ pwm_fan_off;
    end
  end

  // Mode tracker, for visibility only; no assertion reads it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mode_ff <= mcao_pkg::MCAO_IDLE;
    end else begin
      // Shutdown outranks single mode; both bits may be set together
      if (shutdown_request_ff) begin
        mode_ff <= mcao_pkg::MCAO_OFF;
      end else if (single_channel_mode_ff) begin
        mode_ff <= mcao_pkg::MCAO_SINGLE;
      end else begin
        mode_ff <= mcao_pkg::MCAO_SCAN;
      end
    end
  end

  // ==========================================================
  // Submodules
  mcao_offset_add u_add (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .raw_valid    (raw_valid),
    .raw_temp     (raw_remote2),
    .offset       (offset_ff),
    .cor_valid_ff (cor_valid_ff),
    .cor_temp_ff  (cor_remote2_ff)
  );

  mcao_single_channel_mode_seq u_seq (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .single_mode   (single_channel_mode_ff),
    .averaging_off (averaging_disable_ff),
    .halt          (shutdown_request_ff),
    .ext_start_en  (ctrl_ff[mcao_pkg::POS_EXT_START]),
    .ext_start     (ext_start),
    .chan_sel      (ctrl_ff[mcao_pkg::POS_CHAN_LO +: 3]),
    .single_channel_mode_start_ff (single_channel_mode_start_ff),
    .single_channel_mode_chan_ff  (single_channel_mode_chan_ff)
  );

  // ==========================================================
  // Assertions
  lock_blocks_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (locked && wr) |=> $stable(offset_ff) && $stable(config_ff))
    else $error("Write changed a locked register");

  write_lands_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr && !locked && paddr == mcao_pkg::ADDR_CONFIG_TWO) |=> config_ff == $past(pwdata[7:0]))
    else $error("Unlocked config write lost");

  shutdown_request_pwm_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    config_ff[mcao_pkg::POS_SHUTDOWN] ##1 config_ff[mcao_pkg::POS_SHUTDOWN]
      |-> pwm_out_ff == {3{$past(pwm_output_invert)}})
    else $error("PWM not at fan-off level in shutdown");

  shutdown_request_duty_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (acc && !pwrite && paddr == mcao_pkg::ADDR_STATUS_OWN && shutdown_request_ff)
      |=> prdata_ff == 32'h0000_0000)
    else $error("Duty readback not zero in shutdown");

  single_chan_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (single_channel_mode_ff && !shutdown_request_ff && $stable(ctrl_ff)) ##1 single_channel_mode_start_ff
      |-> single_channel_mode_chan_ff == $past(ctrl_ff[mcao_pkg::POS_CHAN_LO +: 3]))
    else $error("Single mode converted wrong channel");

  cfg_fanout_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ##1 fan_two_wire_sense_ff == $past(config_ff[3:0]) && attenuator_bypass_ff == $past(config_ff[5]))
    else $error("Fan sense or bypass not following config");

  offset_add_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (raw_valid && $stable(offset_ff)) |=> cor_remote2_ff
      == 10'($past(raw_remote2) + {{2{$past(offset_ff[7])}}, $past(offset_ff)}))
    else $error("Offset not applied to remote-2 reading");

  apb_answer_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (psel && penable && !pready_ff) |=> pready_ff ##1 !pready_ff)
    else $error("APB answer not one cycle after access");

  avg_fast_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (averaging_disable_ff && !single_channel_mode_ff && single_channel_mode_start_ff
      && $stable(averaging_disable_ff)) |-> ##[1:4] single_channel_mode_start_ff || shutdown_request_ff
      || !averaging_disable_ff || single_channel_mode_ff)
    else $error("Fast conversion pace not kept");
endmodule

// file: test/mcao_top_tb.sv
/*
  Self-checking bench for the configuration and remote-2 offset register block.
  Assumes the design's APB slave, offset adder and sequencer as in mcao_top.
*/
`timescale 1ns/10ps
module mcao_top_tb;
  logic        clk_sys, rst_n, psel, penable, pwrite, raw_valid, ext_start;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, cor_valid_ff, averaging_disable_ff, attenuator_bypass_ff;
  logic        single_channel_mode_ff, shutdown_request_ff, single_channel_mode_start_ff;
  logic [9:0]  raw_remote2, cor_remote2_ff;
  logic [7:0]  duty_now;
  logic [2:0]  pwm_in, pwm_out_ff, single_channel_mode_chan_ff, prev_chan;
  logic [3:0]  fan_two_wire_sense_ff;
  int          bad_count, check_count;

  mcao_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .raw_valid(raw_valid), .raw_remote2(raw_remote2),
    .duty_now(duty_now), .pwm_in(pwm_in), .ext_start(ext_start),
    .cor_valid_ff(cor_valid_ff), .cor_remote2_ff(cor_remote2_ff),
    .fan_two_wire_sense_ff(fan_two_wire_sense_ff), .averaging_disable_ff(averaging_disable_ff),
    .attenuator_bypass_ff(attenuator_bypass_ff), .single_channel_mode_ff(single_channel_mode_ff),
    .shutdown_request_ff(shutdown_request_ff), .pwm_out_ff(pwm_out_ff),
    .single_channel_mode_start_ff(single_channel_mode_start_ff), .single_channel_mode_chan_ff(single_channel_mode_chan_ff));

  // ==========================================================
  // Clock and common tasks
  always #25 clk_sys = ~clk_sys;

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // Request held until the edge where pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      give_verdict();
    end
    rd = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // Waits at most lim edges for a sampled-high flag: 0 corrected valid, 1 start
  task automatic wait_hi(input int sel, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while ((sel == 0 ? cor_valid_ff : single_channel_mode_start_ff) !== 1'b1 && n < lim);
    if (n >= lim) begin
      bad_count++;
      give_verdict();
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    apb(0, mcao_pkg::ADDR_R2_OFFSET, 0); chk(rd, 32'h0, "offset reset");
    apb(0, mcao_pkg::ADDR_CONFIG_TWO, 0); chk(rd, 32'h0, "config reset");
    apb(0, 12'h300, 0); chk(rd, 32'h0, "unmapped read");
    chk({31'h0, pslverr}, 32'h0, "no slave error");
    $display("test reset done");
  endtask

  task automatic t_bits();
    for (int i = 0; i < 8; i++) begin
      apb(1, mcao_pkg::ADDR_CONFIG_TWO, 32'h1 << i);
      repeat (2) @(posedge clk_sys);
      chk({24'h0, shutdown_request_ff, single_channel_mode_ff, attenuator_bypass_ff,
           averaging_disable_ff, fan_two_wire_sense_ff}, 32'h1 << i, "config outputs");
      apb(0, mcao_pkg::ADDR_CONFIG_TWO, 0); chk(rd, 32'h1 << i, "config readback");
    end
    apb(1, mcao_pkg::ADDR_CONFIG_TWO, 0);
    $display("test config bits done");
  endtask

  task automatic t_offset(input logic [7:0] off, input logic [9:0] raw, input logic [9:0] exp);
    apb(1, mcao_pkg::ADDR_R2_OFFSET, {24'h0, off});
    @(posedge clk_sys);
    raw_valid <= 1'b1; raw_remote2 <= raw;
    @(posedge clk_sys);
    raw_valid <= 1'b0;
    wait_hi(0, 4);
    chk({22'h0, cor_remote2_ff}, {22'h0, exp}, "corrected reading");
    $display("test offset %h done", off);
  endtask

  task automatic t_shutdown();
    duty_now <= 8'h5a; pwm_in <= 3'h5;
    apb(1, mcao_pkg::ADDR_CONFIG_TWO, 32'h80);
    repeat (3) @(posedge clk_sys);
    chk({29'h0, pwm_out_ff}, 32'h0, "pwm off level");
    apb(0, mcao_pkg::ADDR_STATUS_OWN, 0); chk(rd, 32'h0, "duty in shutdown");
    apb(1, mcao_pkg::ADDR_CTRL_OWN, 32'h02);
    repeat (3) @(posedge clk_sys);
    chk({29'h0, pwm_out_ff}, 32'h7, "inverted off level");
    apb(1, mcao_pkg::ADDR_CONFIG_TWO, 0);
    repeat (3) @(posedge clk_sys);
    chk({29'h0, pwm_out_ff}, 32'h2, "pwm running inverted");
    apb(0, mcao_pkg::ADDR_STATUS_OWN, 0); chk(rd, 32'h5a, "duty running");
    apb(1, mcao_pkg::ADDR_CTRL_OWN, 0);
    $display("test shutdown done");
  endtask

  task automatic t_single();
    apb(1, mcao_pkg::ADDR_CTRL_OWN, 32'he0);
    apb(1, mcao_pkg::ADDR_CONFIG_TWO, 32'h50);
    repeat (4) @(posedge clk_sys);
    for (int k = 0; k < 3; k++) begin
      wait_hi(1, 80);
      chk({29'h0, single_channel_mode_chan_ff}, {29'h0, mcao_pkg::CHAN_REMOTE2}, "single channel");
    end
    apb(1, mcao_pkg::ADDR_CONFIG_TWO, 32'h10);
    repeat (12) @(posedge clk_sys);
    wait_hi(1, 80);
    prev_chan = single_channel_mode_chan_ff;
    @(posedge clk_sys);
    wait_hi(1, 80);
    chk({29'h0, single_channel_mode_chan_ff}, {29'h0, prev_chan + 3'h1}, "round robin");
    $display("test single channel done");
  endtask

  task automatic t_ext();
    apb(1, mcao_pkg::ADDR_CTRL_OWN, 32'ha4);
    apb(1, mcao_pkg::ADDR_CONFIG_TWO, 32'h50);
    repeat (4) @(posedge clk_sys);
    ext_start <= 1'b1;
    wait_hi(1, 4);
    chk({29'h0, single_channel_mode_chan_ff}, 32'h5, "external start channel");
    ext_start <= 1'b0;
    apb(1, mcao_pkg::ADDR_CTRL_OWN, 0);
    apb(1, mcao_pkg::ADDR_CONFIG_TWO, 0);
    $display("test external start done");
  endtask

  // Lock is sticky until reset, so this runs last
  task automatic t_lock();
    apb(1, mcao_pkg::ADDR_R2_OFFSET, 32'h3c);
    apb(1, mcao_pkg::ADDR_CONFIG_TWO, 32'h21);
    apb(1, mcao_pkg::ADDR_CTRL_OWN, 32'h01);
    apb(1, mcao_pkg::ADDR_R2_OFFSET, 32'hc3);
    apb(1, mcao_pkg::ADDR_CONFIG_TWO, 32'h9e);
    apb(1, mcao_pkg::ADDR_CTRL_OWN, 32'h00);
    apb(1, mcao_pkg::ADDR_CONFIG_TWO, 32'h9e);
    apb(0, mcao_pkg::ADDR_R2_OFFSET, 0); chk(rd, 32'h3c, "locked offset");
    apb(0, mcao_pkg::ADDR_CONFIG_TWO, 0); chk(rd, 32'h21, "locked config");
    chk({31'h0, shutdown_request_ff}, 32'h0, "no shutdown when locked");
    $display("test lock done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    clk_sys = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; raw_valid = 1'b0; raw_remote2 = 10'h000;
    duty_now = 8'h00; pwm_in = 3'h0; ext_start = 1'b0;
    bad_count = 0; check_count = 0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_bits();
    t_offset(8'hfc, 10'h100, 10'h0fc);
    t_offset(8'h05, 10'h3fe, 10'h003);
    t_shutdown();
    t_single();
    t_ext();
    t_lock();
    give_verdict();
  end
endmodule
